// File: hw/epc_pkg.sv
// Package for the nonvolatile configuration memory control block.
package epc_pkg;

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [7:0] OFS_STORED_CRC   = 8'h2F;
    localparam logic [7:0] OFS_CYCLE_COUNT  = 8'h30;
    localparam logic [7:0] OFS_NV_CONTROL   = 8'h31;
    localparam logic [7:0] OFS_LIVE_CRC     = 8'h32;
    localparam logic [7:0] OFS_START_ADDR   = 8'h33;
    localparam logic [7:0] OFS_NV_DATA      = 8'h34;
    localparam logic [7:0] OFS_SRAM_DATA    = 8'h35;
    localparam logic [7:0] OFS_UNLOCK_KEY   = 8'h38;

    // ==========================================================
    // Control register fields
    // ==========================================================
    localparam int BIT_COPY      = 6;
    localparam int BIT_CRC_ERR   = 5;
    localparam int BIT_AUTO_CRC  = 4;
    localparam int BIT_LOAD      = 3;
    localparam int BIT_BUSY      = 2;
    localparam int BIT_ERASE     = 1;
    localparam int BIT_PROG      = 0;
    localparam int ADDR_FIELD_W  = 7;
    localparam int ARRAY_ADDR_W  = 5;

    // ==========================================================
    // Reset values and constants
    // ==========================================================
    localparam logic [7:0] UNLOCK_CODE      = 8'hBE;
    localparam logic [7:0] RST_BYTE         = 8'h00;
    localparam logic       RST_AUTO_CRC     = 1'b1;
    localparam logic [7:0] RST_CYCLE_COUNT  = 8'h01;
    localparam logic [7:0] COUNT_MAX        = 8'hFF;
    localparam logic [7:0] ERASED_BYTE      = 8'h00;
    localparam logic [7:0] CRC_POLY         = 8'h07;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_MHZ      = 100;
    localparam int OP_TIME_MS   = 115;
    localparam int OP_CYCLES    = OP_TIME_MS * CLK_MHZ * 1000;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        EPC_IDLE  = 3'h0,
        EPC_LOAD  = 3'h1,
        EPC_COPY  = 3'h3,
        EPC_ERASE = 3'h2,
        EPC_PROG  = 3'h6,
        EPC_WAIT  = 3'h7
    } epc_state_e;

    typedef struct packed {
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } epc_req_s;

endpackage : epc_pkg

// File: hw/epc_crc8.sv
// One-byte step of the CRC-8 used over the configuration image.
`timescale 1ns/1ps
module epc_crc8 #(
    parameter logic [7:0] POLY = epc_pkg::CRC_POLY
) (
    input  wire logic [7:0] crc_in,   // Running CRC
    input  wire logic [7:0] data_in,  // Next data byte
    output logic      [7:0] crc_out   // CRC after the byte
);
    always_comb begin
        logic [7:0] c;
        c = crc_in ^ data_in;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ POLY) : (c << 1);
        end
        crc_out = c;
    end
endmodule : epc_crc8

// File: hw/epc_ctrl.sv
// Nonvolatile configuration memory control: load, copy, erase, program, CRC, data ports.
`timescale 1ns/1ps
// Notes on behaviour
// - Copy bit copies every register into the SRAM image, then clears itself.
// - CRC error flag set when load readback CRC mismatches, else reads zero.
// - With auto CRC enabled (reset one), programming computes and stores CRC.
// - Load bit transfers nonvolatile contents into registers, then clears itself.
// - Load runs automatically after every reset.
// - Register reads are not served while a load runs.
// - Busy flag is one during erase or program; nonvolatile access blocked.
// - Erase starts only if the previous transaction wrote the unlock key.
// - Program starts only if the previous transaction wrote the unlock key.
// - Erase and program written together run erase then program.
// - Erase takes about 115 ms with busy asserted.
// - Program takes about 115 ms with busy asserted.
// - Read-only eight-bit live CRC, resets to zero.
// - Seven-bit writable start address field, resets to zero.
// - Internal address auto-increments; start field keeps its written value.
// - Only the low five start address bits form the array byte address.
// - Nonvolatile data port reads from the programmed start address onward.
// - SRAM data port gives read and write access to the SRAM image.
// - Cycle counter increments after each program, not after an erase alone, saturating at 255.
// - Stored CRC from nonvolatile memory readable as a read-only byte.
module epc_ctrl #(
    parameter int NB        = 32,                 // Bytes in each array
    parameter int OP_CYCLES = epc_pkg::OP_CYCLES  // Cycles per erase or program
) (
    input  wire logic                 clk,        // 100 MHz clock
    input  wire logic                 rst,        // Asynchronous reset, active high
    input  wire logic                 req_valid,  // One-cycle bus transaction strobe
    input  wire epc_pkg::epc_req_s    req,        // Transaction: write, address, data
    output logic                      rd_valid,   // Read data valid pulse
    output logic [7:0]                rd_data,    // Read data
    output logic                      rd_refused, // Read dropped during load
    output logic                      busy,       // Erase or program in progress
    output logic [NB-1:0][7:0]        cfg_q       // Configuration registers
);
    localparam int AW = epc_pkg::ARRAY_ADDR_W;

    // ==========================================================
    // Storage
    // ==========================================================
    logic [7:0]  sram_q [NB];
    logic [7:0]  nvm_q  [NB];
    logic [7:0]  nvm_crc_q;      // Stored CRC byte held in the array
    logic [7:0]  nvm_cnt_q;      // Cycle count byte held in the array

    // ==========================================================
    // Control state
    // ==========================================================
    epc_pkg::epc_state_e state_q, state_d;
    logic [AW-1:0]   idx_q;
    logic [31:0]     timer_q;
    logic            prog_after_q;
    logic            erase_run_q;
    logic            prog_run_q;
    logic            auto_crc_q;
    logic            crc_err_q;
    logic [7:0]      live_crc_q;
    logic [7:0]      run_crc_q;
    logic [7:0]      stored_crc_q;
    logic [7:0]      cnt_q;
    logic [epc_pkg::ADDR_FIELD_W-1:0] start_addr_q;
    logic [AW-1:0]   ptr_q;
    logic [7:0]      key_q;
    logic            unlocked_q;

    // ==========================================================
    // Decode
    // ==========================================================
    wire is_wr    = req_valid & req.write;
    wire is_rd    = req_valid & ~req.write;
    wire hit_ctl  = req.addr == epc_pkg::OFS_NV_CONTROL;
    wire hit_adr  = req.addr == epc_pkg::OFS_START_ADDR;
    wire hit_nvd  = req.addr == epc_pkg::OFS_NV_DATA;
    wire hit_srd  = req.addr == epc_pkg::OFS_SRAM_DATA;
    wire hit_key  = req.addr == epc_pkg::OFS_UNLOCK_KEY;
    wire loading  = state_q == epc_pkg::EPC_LOAD;
    wire idle     = state_q == epc_pkg::EPC_IDLE;
    wire busy_now = erase_run_q | prog_run_q;
    wire last_idx = idx_q == AW'(NB - 1);
    wire timer_done = timer_q == 32'(OP_CYCLES - 1);

    wire ctl_wr    = is_wr & hit_ctl;
    wire go_erase  = ctl_wr & req.wdata[epc_pkg::BIT_ERASE] & unlocked_q & idle;
    wire go_prog   = ctl_wr & req.wdata[epc_pkg::BIT_PROG]  & unlocked_q & idle;
    wire go_load   = ctl_wr & req.wdata[epc_pkg::BIT_LOAD] & idle;
    wire go_copy   = ctl_wr & req.wdata[epc_pkg::BIT_COPY] & idle;
    wire key_ok    = is_wr & hit_key & (req.wdata == epc_pkg::UNLOCK_CODE);

    // Array ports are closed whenever the sequencer owns the arrays.
    wire nvd_rd    = is_rd & hit_nvd & idle;
    wire srd_rd    = is_rd & hit_srd & idle;
    wire srd_wr    = is_wr & hit_srd & idle;
    wire port_hit  = nvd_rd | srd_rd | srd_wr;

    logic [7:0] crc_next;
    wire  [7:0] crc_data = (state_q == epc_pkg::EPC_LOAD) ? nvm_q[idx_q] : sram_q[idx_q];

    epc_crc8 #(
        .POLY    (epc_pkg::CRC_POLY)
    ) u_crc (
        .crc_in  (run_crc_q),
        .data_in (crc_data),
        .crc_out (crc_next)
    );

    wire [7:0] ctl_rd = {1'b0,
                         state_q == epc_pkg::EPC_COPY,
                         crc_err_q,
                         auto_crc_q,
                         loading,
                         busy_now,
                         erase_run_q,
                         prog_run_q};

    logic [7:0] rd_mux;
    always_comb begin
        if (hit_ctl) begin
            rd_mux = ctl_rd;
        end else if (req.addr == epc_pkg::OFS_LIVE_CRC) begin
            rd_mux = live_crc_q;
        end else if (req.addr == epc_pkg::OFS_STORED_CRC) begin
            rd_mux = stored_crc_q;
        end else if (req.addr == epc_pkg::OFS_CYCLE_COUNT) begin
            rd_mux = cnt_q;
        end else if (hit_adr) begin
            rd_mux = {1'b0, start_addr_q};
        end else if (hit_nvd) begin
            rd_mux = idle ? nvm_q[ptr_q] : epc_pkg::RST_BYTE;
        end else if (hit_srd) begin
            rd_mux = idle ? sram_q[ptr_q] : epc_pkg::RST_BYTE;
        end else if (hit_key) begin
            rd_mux = key_q;
        end else begin
            rd_mux = epc_pkg::RST_BYTE;
        end
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    always_comb begin
        state_d = state_q;
        case (state_q)
            epc_pkg::EPC_IDLE: begin
                if (go_erase) begin
                    state_d = epc_pkg::EPC_ERASE;
                end else if (go_prog) begin
                    state_d = epc_pkg::EPC_PROG;
                end else if (go_load) begin
                    state_d = epc_pkg::EPC_LOAD;
                end else if (go_copy) begin
                    state_d = epc_pkg::EPC_COPY;
                end
            end
            epc_pkg::EPC_LOAD, epc_pkg::EPC_COPY: begin
                if (last_idx) begin
                    state_d = epc_pkg::EPC_IDLE;
                end
            end
            epc_pkg::EPC_ERASE, epc_pkg::EPC_PROG: begin
                if (last_idx) begin
                    state_d = epc_pkg::EPC_WAIT;
                end
            end
            epc_pkg::EPC_WAIT: begin
                if (timer_done) begin
                    state_d = (erase_run_q & prog_after_q) ? epc_pkg::EPC_PROG
                                                           : epc_pkg::EPC_IDLE;
                end
            end
            default: state_d = epc_pkg::EPC_IDLE;
        endcase
    end

    wire sweep    = (state_q != epc_pkg::EPC_IDLE) & (state_q != epc_pkg::EPC_WAIT);
    wire op_end   = (state_q == epc_pkg::EPC_WAIT) & timer_done;
    wire prog_end = op_end & prog_run_q;
    wire erase_to_prog = op_end & erase_run_q & prog_after_q;

    // Reset leaves the sequencer in the load state so the image is restored at once.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= epc_pkg::EPC_LOAD;
            idx_q   <= '0;
            timer_q <= '0;
        end else begin
            state_q <= state_d;
            idx_q   <= (sweep && !last_idx) ? idx_q + AW'(1) : '0;
            timer_q <= (state_q == epc_pkg::EPC_WAIT && !timer_done) ? timer_q + 32'd1 : '0;
        end
    end

    // ==========================================================
    // Operation flags and busy
    // ==========================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            erase_run_q  <= 1'b0;
            prog_run_q   <= 1'b0;
            prog_after_q <= 1'b0;
            busy         <= 1'b0;
        end else begin
            if (go_erase) begin
                erase_run_q  <= 1'b1;
                prog_after_q <= go_prog;
            end else if (go_prog || erase_to_prog) begin
                erase_run_q  <= 1'b0;
                prog_run_q   <= 1'b1;
            end else if (op_end) begin
                erase_run_q  <= 1'b0;
                prog_run_q   <= 1'b0;
                prog_after_q <= 1'b0;
            end
            busy <= (busy_now & ~(op_end & ~erase_to_prog)) | go_erase | go_prog;
        end
    end

    // ==========================================================
    // CRC, counter and flags
    // ==========================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_crc_q    <= epc_pkg::RST_BYTE;
            live_crc_q   <= epc_pkg::RST_BYTE;
            crc_err_q    <= 1'b0;
            stored_crc_q <= epc_pkg::RST_BYTE;
            cnt_q        <= epc_pkg::RST_CYCLE_COUNT;
            auto_crc_q   <= epc_pkg::RST_AUTO_CRC;
        end else begin
            if (ctl_wr) begin
                auto_crc_q <= req.wdata[epc_pkg::BIT_AUTO_CRC];
            end
            if (state_q == epc_pkg::EPC_LOAD || state_q == epc_pkg::EPC_PROG) begin
                run_crc_q <= last_idx ? epc_pkg::RST_BYTE : crc_next;
                if (last_idx) begin
                    live_crc_q <= crc_next;
                end
            end
            if (loading && last_idx) begin
                crc_err_q    <= crc_next != nvm_crc_q;
                stored_crc_q <= nvm_crc_q;
                cnt_q        <= nvm_cnt_q;
            end else if (prog_end) begin
                stored_crc_q <= auto_crc_q ? live_crc_q : nvm_crc_q;
                cnt_q        <= (nvm_cnt_q == epc_pkg::COUNT_MAX) ? nvm_cnt_q
                                                                  : nvm_cnt_q + 8'd1;
            end
        end
    end

    // Array contents are nonvolatile and deliberately carry no reset.
    always_ff @(posedge clk) begin
        if (state_q == epc_pkg::EPC_ERASE) begin
            nvm_q[idx_q] <= epc_pkg::ERASED_BYTE;
        end else if (state_q == epc_pkg::EPC_PROG) begin
            nvm_q[idx_q] <= sram_q[idx_q];
        end
        if (prog_end) begin
            if (auto_crc_q) begin
                nvm_crc_q <= live_crc_q;
            end
            nvm_cnt_q <= (nvm_cnt_q == epc_pkg::COUNT_MAX) ? nvm_cnt_q
                                                           : nvm_cnt_q + 8'd1;
        end
        if (state_q == epc_pkg::EPC_COPY) begin
            sram_q[idx_q] <= cfg_q[idx_q];
        end else if (srd_wr) begin
            sram_q[ptr_q] <= req.wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q <= '0;
        end else if (loading) begin
            cfg_q[idx_q] <= nvm_q[idx_q];
        end
    end

    // ==========================================================
    // Host-facing registers
    // ==========================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_addr_q <= '0;
            ptr_q        <= '0;
            key_q        <= epc_pkg::RST_BYTE;
            unlocked_q   <= 1'b0;
        end else begin
            if (is_wr && hit_adr) begin
                start_addr_q <= req.wdata[epc_pkg::ADDR_FIELD_W-1:0];
                ptr_q        <= req.wdata[AW-1:0];
            end else if (port_hit) begin
                ptr_q <= ptr_q + AW'(1);
            end
            if (is_wr && hit_key) begin
                key_q <= req.wdata;
            end
            if (req_valid) begin
                unlocked_q <= key_ok;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_valid   <= 1'b0;
            rd_data    <= epc_pkg::RST_BYTE;
            rd_refused <= 1'b0;
        end else begin
            rd_valid   <= is_rd & ~loading;
            rd_refused <= is_rd & loading;
            if (is_rd && !loading) begin
                rd_data <= rd_mux;
            end
        end
    end

endmodule : epc_ctrl

// File: sim/epc_ctrl_asserts.sv
// Port assertions for the nonvolatile memory control block.
`timescale 1ns/1ps
module epc_ctrl_asserts #(
    parameter int NB        = 32, // Bytes in each array
    parameter int OP_CYCLES = epc_pkg::OP_CYCLES // Cycles per erase or program
) (
    input wire logic              clk,        // Clock
    input wire logic              rst,        // Asynchronous reset
    input wire logic              req_valid,  // Transaction strobe
    input wire epc_pkg::epc_req_s req,        // Transaction
    input wire logic              rd_valid,   // Read answered
    input wire logic [7:0]        rd_data,    // Read data
    input wire logic              rd_refused, // Read dropped
    input wire logic              busy        // Erase or program running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Helper state
    // ==========================================================
    logic [7:0] ld_q;
    logic [7:0] quiet_q;
    logic       unl_q;
    int         busy_n_q;
    wire rd_req = req_valid && !req.write;
    wire ctl_wr = req_valid && req.write && req.addr == epc_pkg::OFS_NV_CONTROL;
    wire key_wr = req_valid && req.write && req.addr == epc_pkg::OFS_UNLOCK_KEY
                  && req.wdata == epc_pkg::UNLOCK_CODE;
    // Load and copy keep the sequencer away from idle, so starts are only judged after them.
    wire slow   = ctl_wr && (req.wdata[6] || req.wdata[3]);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ld_q     <= 8'h00;
            quiet_q  <= 8'h00;
            unl_q    <= 1'b0;
            busy_n_q <= 0;
        end else begin
            ld_q     <= ld_q + 8'(ld_q != 8'hFF);
            quiet_q  <= slow ? 8'h00 : quiet_q + 8'(quiet_q != 8'hFF);
            unl_q    <= req_valid ? key_wr : unl_q;
            busy_n_q <= busy ? busy_n_q + 1 : 0;
        end
    end
    // ==========================================================
    // Properties
    // ==========================================================
    sequence s_start_ok;
        ctl_wr && (req.wdata[1] || req.wdata[0]) && unl_q && !busy && quiet_q >= 2 * NB;
    endsequence
    sequence s_busy_read(logic [7:0] a);
        rd_req && req.addr == a && busy;
    endsequence
    a_read_answered: assert property (rd_req |=> rd_valid != rd_refused)
        else $error("read did not get exactly one answer");
    a_answer_caused: assert property ((rd_valid || rd_refused) |-> $past(rd_req))
        else $error("read answer without a read");
    a_load_refuses: assert property (rd_req && ld_q < NB - 1 |=> rd_refused)
        else $error("read served during automatic load");
    a_unlock_starts: assert property (s_start_ok |=> busy [*2])
        else $error("unlocked start did not raise busy");
    a_no_key_no_start: assert property (ctl_wr && !unl_q && !busy |=> !busy)
        else $error("cycle started without unlock");
    a_busy_span: assert property ($fell(busy) |->
        busy_n_q >= NB + OP_CYCLES - 2 && busy_n_q <= 2 * (NB + OP_CYCLES) + 8)
        else $error("busy length out of range");
    a_busy_visible: assert property (s_busy_read(epc_pkg::OFS_NV_CONTROL)
        |=> rd_valid && rd_data[epc_pkg::BIT_BUSY])
        else $error("busy bit not shown in control read");
    a_port_blocked: assert property (s_busy_read(epc_pkg::OFS_NV_DATA)
        |=> rd_valid && rd_data == 8'h00)
        else $error("array read served while busy");
endmodule : epc_ctrl_asserts

bind epc_ctrl epc_ctrl_asserts #(.NB(NB), .OP_CYCLES(OP_CYCLES)) u_asserts (.clk(clk),
    .rst(rst), .req_valid(req_valid), .req(req), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_refused(rd_refused), .busy(busy));

// File: sim/epc_host.sv
// Host model issuing register transactions to the device.
`timescale 1ns/1ps
module epc_host (
    input  wire logic         clk,        // Device clock
    output epc_pkg::epc_req_s req,        // Transaction
    output logic              req_valid,  // Transaction strobe
    input  wire logic         rd_valid,   // Read answered
    input  wire logic         rd_refused, // Read dropped
    input  wire logic [7:0]   rd_data     // Read data
);
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    // A released bus shows the inverse of the last values, never a stale copy.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req_valid = 1'b1;
        req = '{write: w, addr: a, wdata: d};
        @(negedge clk);
        req_valid = 1'b0;
        req = '{write: ~w, addr: ~a, wdata: ~d};
    endtask : xfer
    // The answer pulse stands for one cycle, so it is taken at the falling edge that xfer ends on.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] s);
        xfer(1'b0, a, 8'h00);
        d = rd_data;
        s = {rd_refused, rd_valid};
    endtask : rd
    task automatic unlock();
        xfer(1'b1, epc_pkg::OFS_UNLOCK_KEY, epc_pkg::UNLOCK_CODE);
    endtask : unlock
endmodule : epc_host

// File: sim/epc_ctrl_tb.sv
// Testbench for the nonvolatile memory control block.
`timescale 1ns/1ps
module epc_ctrl_tb;
    // ==========================================================
    // Bench state
    // ==========================================================
    localparam int NB  = 32;
    localparam int OPC = 20;
    logic               clk;
    logic               rst;
    logic               req_valid;
    epc_pkg::epc_req_s  req;
    logic               rd_valid;
    logic               rd_refused;
    logic [7:0]         rd_data;
    logic               busy;
    logic [NB-1:0][7:0] cfg_q;
    logic [7:0]         v;
    logic [7:0]         scrc;
    logic [6:0]         sa;
    logic [1:0]         st;
    int                 fails;
    int                 checks_done;
    int                 sram[NB];
    int                 nv[NB];

    epc_ctrl #(.NB(NB), .OP_CYCLES(OPC)) uut (.clk(clk), .rst(rst), .req_valid(req_valid),
        .req(req), .rd_valid(rd_valid), .rd_data(rd_data), .rd_refused(rd_refused),
        .busy(busy), .cfg_q(cfg_q));
    epc_host host (.clk(clk), .req(req), .req_valid(req_valid), .rd_valid(rd_valid),
        .rd_refused(rd_refused), .rd_data(rd_data));

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, v, st);
        chk({6'h00, st}, 8'h01);
        chk(v, e);
    endtask : rdchk
    function automatic logic [7:0] crc_of(input int b[NB]);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < NB; i++) begin
            c = c ^ 8'(b[i]);
            for (int k = 0; k < 8; k++) c = {c[6:0], 1'b0} ^ (c[7] ? epc_pkg::CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc_of
    task automatic fill(input logic [6:0] s);
        wr(epc_pkg::OFS_START_ADDR, {1'b0, s});
        for (int i = 0; i < NB; i++) begin
            sram[(s[4:0] + i) % NB] = $urandom % 256;
            wr(epc_pkg::OFS_SRAM_DATA, 8'(sram[(s[4:0] + i) % NB]));
        end
    endtask : fill
    task automatic dump(input logic [7:0] a, input int m[NB], input logic [6:0] s);
        wr(epc_pkg::OFS_START_ADDR, {1'b0, s});
        for (int i = 0; i < NB; i++) rdchk(a, 8'(m[(s[4:0] + i) % NB]));
    endtask : dump
    // Mode 0 skips the unlock, mode 2 puts a read between unlock and start.
    task automatic nvop(input logic [7:0] ctl, input int mode);
        int n;
        int m;
        n = 0;
        m = (ctl[1] & ctl[0] ? 2 : 1) * (NB + OPC);
        if (mode > 0) host.unlock();
        if (mode == 2) host.rd(epc_pkg::OFS_LIVE_CRC, v, st);
        wr(epc_pkg::OFS_NV_CONTROL, ctl);
        @(negedge clk);
        chk({7'h00, busy}, 8'(mode == 1));
        if (mode == 1) begin
            rdchk(epc_pkg::OFS_NV_DATA, 8'h00);
            host.rd(epc_pkg::OFS_NV_CONTROL, v, st);
            chk(v & 8'h04, 8'h04);
            while (busy === 1'b1 && n < 4 * (NB + OPC)) begin
                @(negedge clk);
                n++;
            end
            chk(8'(n > m - 12 && n <= m), 8'h01);
            chk({7'h00, busy}, 8'h00);
            for (int i = 0; i < NB; i++) nv[i] = ctl[0] ? sram[i] : 0;
            if (ctl[0] && ctl[4]) scrc = crc_of(sram);
        end
    endtask : nvop
    task automatic load(input logic err);
        wr(epc_pkg::OFS_NV_CONTROL, 8'h18);
        host.rd(epc_pkg::OFS_LIVE_CRC, v, st);
        chk({6'h00, st}, 8'h02);
        repeat (NB + 2) @(negedge clk);
        for (int i = 0; i < NB; i++) chk(cfg_q[i], 8'(nv[i]));
        rdchk(epc_pkg::OFS_LIVE_CRC, crc_of(nv));
        host.rd(epc_pkg::OFS_NV_CONTROL, v, st);
        chk(v & 8'h78, {2'b00, err, 5'h10});
    endtask : load

    // ==========================================================
    // Clock, watchdog and tests
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #300000;
        fails++;
        results();
    end
    initial begin
        fails = 0;
        checks_done = 0;
        rst = 1'b1;
        void'($urandom(32'h579D2B00));
        repeat (16) @(negedge clk);
        rst = 1'b0;
        host.rd(epc_pkg::OFS_START_ADDR, v, st);
        chk({6'h00, st}, 8'h02);
        repeat (NB + 2) @(negedge clk);
        rdchk(epc_pkg::OFS_START_ADDR, 8'h00);
        rdchk(epc_pkg::OFS_UNLOCK_KEY, 8'h00);
        host.rd(epc_pkg::OFS_NV_CONTROL, v, st);
        chk(v & 8'hDF, 8'h10);
        $display("reset test done");
        sa = 7'($urandom);
        fill(sa);
        rdchk(epc_pkg::OFS_START_ADDR, {1'b0, sa});
        dump(epc_pkg::OFS_SRAM_DATA, sram, sa ^ 7'h60);
        $display("sram test done");
        nvop(8'h11, 0);
        nvop(8'h11, 2);
        nvop(8'h13, 1);
        dump(epc_pkg::OFS_NV_DATA, nv, 7'h00);
        rdchk(epc_pkg::OFS_STORED_CRC, scrc);
        load(1'b0);
        $display("program test done");
        fill(7'h05);
        wr(epc_pkg::OFS_NV_CONTROL, 8'h50);
        repeat (NB + 4) @(negedge clk);
        host.rd(epc_pkg::OFS_NV_CONTROL, v, st);
        chk(v & 8'h40, 8'h00);
        sram = nv;
        dump(epc_pkg::OFS_SRAM_DATA, sram, 7'h00);
        $display("copy test done");
        fill(7'h1F);
        nvop(8'h01, 1);
        rdchk(epc_pkg::OFS_STORED_CRC, scrc);
        load(crc_of(nv) !== scrc);
        nvop(8'h12, 1);
        dump(epc_pkg::OFS_NV_DATA, nv, 7'h00);
        $display("crc and erase test done");
        results();
    end
endmodule : epc_ctrl_tb
